// >>> bench/pbm_pin_load.sv
/*
 Pin load model for the port B mux: resolves each pin from the port drive,
 an external driver and the pull-up. Assumes registered port outputs.
*/
`timescale 1ns/1ps
module pbm_pin_load (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] level_o
);
  // ==========================================================
  // Floating pins
  // Undriven, unpulled pins change every cycle so no stale value passes
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
            | (~oe_i & ~ext_en_i & pullup_i) | (~oe_i & ~ext_en_i & ~pullup_i & float_q);
  end
endmodule

// >>> bench/pbm_port_tb.sv
/*
 Testbench for the port B mux: Wishbone register tests and pin checks.
 Assumes one-cycle registered ack and registered pin outputs.
*/
`timescale 1ns/1ps
module pbm_port_tb;
  import pbm_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hw = 0, xe = 0;
  logic [3:0] adr = 4'h0, sel = 4'hf;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic [2:0] mode = PBM_MODE_7;
  logic [7:0] addr_b = 8'h96, lvl, p_o, p_oe, p_pu, ext_en = 8'hff;
  logic [7:0] dir_v = 8'h00, dr_v = 8'h00, pcr_v = 8'h00;
  logic wb_ack_o, ce = 1'b1;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  pbm_port i_pbm_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_i(mode), .expansion_enable_i(xe),
    .hw_standby_i(hw), .addr_byte_i(addr_b), .pin_i(lvl), .pin_o(p_o),
    .pin_oe_o(p_oe), .pullup_o(p_pu));
  pbm_pin_load i_pbm_pin_load (.clk_i(clk_i), .drv_i(p_o), .oe_i(p_oe), .pullup_i(p_pu),
    .ext_en_i(ext_en), .ext_val_i(8'h3c), .level_o(lvl));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    // This wait ends on ack, or on the bench timeout if no ack comes
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    xfer(0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic pins(input logic [2:0] m, input logic x, input logic h);
    logic [7:0] oe, o, pu;
    @(posedge clk_i);
    mode <= m; xe <= x; hw <= h;
    repeat (3) @(posedge clk_i);
    oe = 8'h00; o = 8'h00; pu = 8'h00;
    if (m == PBM_MODE_1 || m == PBM_MODE_2) begin
      oe = 8'hff; o = addr_b;
    end else if (m == PBM_MODE_4 || (m == PBM_MODE_7 && x)) begin
      oe = dir_v; o = addr_b & dir_v; pu = ~dir_v & pcr_v;
    end else if (m == PBM_MODE_7) begin
      oe = dir_v; o = dr_v & dir_v; pu = ~dir_v & pcr_v;
    end
    if (h) pu = 8'h00;
    chk("pin_oe", {24'h0, oe}, {24'h0, p_oe});
    chk("pin_o", {24'h0, o}, {24'h0, p_o});
    chk("pullup", {24'h0, pu}, {24'h0, p_pu});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Timeout
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rchk("output_data", PBM_OFS_OUT_DATA, 32'h0);
    rchk("pullup_control", PBM_OFS_PULLUP, 32'h0);
    rchk("pin_direction", PBM_OFS_DIRECTION, PBM_UNDEF_READ);
    rchk("pin_level_read", PBM_OFS_PIN_LEVEL, 32'h3c);
    pins(PBM_MODE_7, 0, 0);
    $display("test reset done");
    dir_v = 8'h0f; dr_v = 8'ha5; pcr_v = 8'hf3;
    xfer(1, PBM_OFS_DIRECTION, dir_v);
    xfer(1, PBM_OFS_OUT_DATA, dr_v);
    xfer(1, PBM_OFS_PULLUP, pcr_v);
    xfer(1, PBM_OFS_PIN_LEVEL, 8'hff);
    rchk("pin_level_read", PBM_OFS_PIN_LEVEL, 32'h35);
    rchk("output_data", PBM_OFS_OUT_DATA, 32'ha5);
    rchk("pullup_control", PBM_OFS_PULLUP, 32'hf3);
    rchk("unmapped", 4'h2, 32'h0);
    sel <= 4'he;
    xfer(1, PBM_OFS_OUT_DATA, 8'h5a);
    sel <= 4'hf;
    rchk("output_data_sel", PBM_OFS_OUT_DATA, 32'ha5);
    $display("test registers done");
    pins(PBM_MODE_7, 0, 0);
    pins(PBM_MODE_1, 0, 0);
    pins(PBM_MODE_2, 1, 0);
    pins(PBM_MODE_4, 0, 0);
    pins(PBM_MODE_4, 1, 0);
    pins(PBM_MODE_7, 1, 0);
    pins(PBM_MODE_4, 0, 1);
    addr_b <= 8'h69;
    pins(PBM_MODE_4, 0, 0);
    pins(3'h3, 0, 0);
    $display("test modes done");
    ext_en <= 8'h00;
    pins(PBM_MODE_4, 0, 0);
    rchk("pin_level_read", PBM_OFS_PIN_LEVEL, 32'hf5);
    $display("test pullup done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pullup_in_reset", 32'h0, {24'h0, p_pu});
    chk("pin_oe_in_reset", 32'h0, {24'h0, p_oe});
    rst_i <= 1'b0;
    dir_v = 8'h00; dr_v = 8'h00; pcr_v = 8'h00;
    rchk("output_data", PBM_OFS_OUT_DATA, 32'h0);
    rchk("pullup_control", PBM_OFS_PULLUP, 32'h0);
    pins(PBM_MODE_4, 0, 0);
    $display("test reset again done");
    ce <= 1'b0;
    mode <= PBM_MODE_1;
    repeat (3) @(posedge clk_i);
    chk("pin_oe_frozen", 32'h0, {24'h0, p_oe});
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pin_oe_thawed", 32'hff, {24'h0, p_oe});
    $display("test freeze done");
    wrap_up();
  end
endmodule

// >>> hdl/pbm_pin_select.sv
/*
 Per-pin function selector: address out, general out or input, and pull-up.
 Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module pbm_pin_select
  import pbm_pkg::*;
(
  input  wire logic [2:0] mode_i,
  input  wire logic       expansion_enable_i,
  input  wire logic       hw_standby_i,
  input  wire logic       dir_i,
  input  wire logic       pullup_bit_i,
  output pbm_fn_t         fn_o,
  output logic            pullup_on_o
);
  logic mode_addr;
  logic mode_pullup;

  always_comb begin
    mode_addr   = (mode_i == PBM_MODE_1) || (mode_i == PBM_MODE_2);
    mode_pullup = (mode_i == PBM_MODE_4) || (mode_i == PBM_MODE_7);
    // Expansion bit only consulted in mode seven
    if (mode_addr) begin
      fn_o = PBM_FN_ADDR_OUT;
    end else if (mode_i == PBM_MODE_4 || (mode_i == PBM_MODE_7 && expansion_enable_i)) begin
      fn_o = dir_i ? PBM_FN_ADDR_OUT : PBM_FN_INPUT;
    end else if (mode_i == PBM_MODE_7) begin
      fn_o = dir_i ? PBM_FN_GP_OUT : PBM_FN_INPUT;
    end else begin
      // Unsupported mode: keep the pin safe as an input
      fn_o = PBM_FN_INPUT;
    end
    pullup_on_o = mode_pullup && !hw_standby_i && !dir_i && pullup_bit_i;
  end
endmodule

// >>> hdl/pbm_pkg.sv
/*
 Package for the port B address / I/O mux: register offsets, field widths,
 reset values, mode encodings.
 Assumes a classic Wishbone slave with 32-bit data and byte addressing.
*/
// Contract
// - Eight pins, each general input, general output or address bit 15..8 output
// - Direction register write-only, resets to zero, reads return undefined value
// - Modes one and two: every pin outputs its address bit regardless
// - Mode four, or seven with expansion: direction one is address, zero is input
// - Mode seven without expansion: direction one drives output data, zero is input
// - Selection depends on mode, expansion bit, direction; expansion ignored in 1, 2, 4
// - Output data register read/write, resets to zero, feeds general outputs
// - Pin-state read returns output data where direction one, pin level where zero
// - Pin-state register read-only; after reset it reflects the pins
// - Pull-up register read/write, resets zero, per pin, effective only modes 4, 7
// - Modes 4 and 7 running or soft standby: pull-up on iff direction 0, bit 1
// - Pull-ups off in modes 1, 2 always, and in reset and hardware standby
package pbm_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] PBM_OFS_DIRECTION = 4'h0;
  localparam logic [3:0] PBM_OFS_OUT_DATA  = 4'h4;
  localparam logic [3:0] PBM_OFS_PIN_LEVEL = 4'h8;
  localparam logic [3:0] PBM_OFS_PULLUP    = 4'hc;
  localparam int         PBM_ADDR_W        = 4;
  localparam int         PBM_PINS          = 8;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  PBM_RST_DIRECTION = 8'h00;
  localparam logic [7:0]  PBM_RST_OUT_DATA  = 8'h00;
  localparam logic [7:0]  PBM_RST_PULLUP    = 8'h00;
  localparam logic [31:0] PBM_UNDEF_READ    = 32'h0000_00ff;

  // ==========================================================
  // Operating mode encodings
  localparam logic [2:0] PBM_MODE_1 = 3'h1;
  localparam logic [2:0] PBM_MODE_2 = 3'h2;
  localparam logic [2:0] PBM_MODE_4 = 3'h4;
  localparam logic [2:0] PBM_MODE_7 = 3'h7;

  typedef enum logic [1:0] {
    PBM_FN_INPUT,
    PBM_FN_GP_OUT,
    PBM_FN_ADDR_OUT
  } pbm_fn_t;
endpackage

// >>> hdl/pbm_port.sv
/*
 Port B address / general I/O mux with Wishbone register access.
 Assumes a classic Wishbone master, synchronous pin inputs, and quasi-static
 mode and expansion inputs from the system controller.
*/
`timescale 1ns/1ps
module pbm_port
  import pbm_pkg::*;
#(
  parameter int PINS = PBM_PINS
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [PBM_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // System control
  input  wire logic [2:0]            mode_i,
  input  wire logic                  expansion_enable_i,
  input  wire logic                  hw_standby_i,
  // Address byte from the bus controller
  input  wire logic [PINS-1:0]       addr_byte_i,
  // Pins
  input  wire logic [PINS-1:0]       pin_i,
  output logic      [PINS-1:0]       pin_o,
  output logic      [PINS-1:0]       pin_oe_o,
  output logic      [PINS-1:0]       pullup_o
);
  // ==========================================================
  // Register state
  logic [PINS-1:0] pin_direction_reg;
  logic [PINS-1:0] pin_direction_next;
  logic [PINS-1:0] output_data_reg;
  logic [PINS-1:0] output_data_next;
  logic [PINS-1:0] pullup_control_reg;
  logic [PINS-1:0] pullup_control_next;
  logic [31:0]     wb_dat_reg;
  logic [31:0]     wb_dat_next;
  logic            wb_ack_reg;
  logic            wb_ack_next;
  logic [PINS-1:0] pin_reg;
  logic [PINS-1:0] pin_next;
  logic [PINS-1:0] pin_oe_reg;
  logic [PINS-1:0] pin_oe_next;
  logic [PINS-1:0] pullup_reg;
  logic [PINS-1:0] pullup_next;

  pbm_fn_t         fn      [PINS];
  logic [PINS-1:0] pull_sel;
  logic            wr_req;
  logic            rd_req;

  // ==========================================================
  // Per-pin selectors
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    pbm_pin_select u_sel (
      .mode_i             (mode_i),
      .expansion_enable_i (expansion_enable_i),
      .hw_standby_i       (hw_standby_i),
      .dir_i              (pin_direction_reg[g]),
      .pullup_bit_i       (pullup_control_reg[g]),
      .fn_o               (fn[g]),
      .pullup_on_o        (pull_sel[g])
    );
  end

  function automatic logic [PINS-1:0] pin_state_view(
    input logic [PINS-1:0] dir,
    input logic [PINS-1:0] dr,
    input logic [PINS-1:0] lvl
  );
    pin_state_view = (dir & dr) | (~dir & lvl);
  endfunction

  // ==========================================================
  // Wishbone slave: one registered ack, a cycle after the request, dropped the cycle after
  always_comb begin
    wr_req              = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_reg && wb_sel_i[0];
    rd_req              = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_reg;
    pin_direction_next  = pin_direction_reg;
    output_data_next    = output_data_reg;
    pullup_control_next = pullup_control_reg;
    wb_ack_next         = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    wb_dat_next         = 32'h0000_0000;
    if (wr_req) begin
      unique case (wb_adr_i)
        PBM_OFS_DIRECTION: pin_direction_next  = wb_dat_i[PINS-1:0];
        PBM_OFS_OUT_DATA:  output_data_next    = wb_dat_i[PINS-1:0];
        PBM_OFS_PULLUP:    pullup_control_next = wb_dat_i[PINS-1:0];
        // Pin-state and unmapped writes are acknowledged and dropped
        default:           ;
      endcase
    end
    if (rd_req) begin
      unique case (wb_adr_i)
        // Direction is not readable; a fixed junk pattern comes back
        PBM_OFS_DIRECTION: wb_dat_next = PBM_UNDEF_READ;
        PBM_OFS_OUT_DATA:  wb_dat_next = {{(32-PINS){1'b0}}, output_data_reg};
        PBM_OFS_PIN_LEVEL: wb_dat_next = {{(32-PINS){1'b0}},
                                          pin_state_view(pin_direction_reg,
                                                         output_data_reg, pin_i)};
        PBM_OFS_PULLUP:    wb_dat_next = {{(32-PINS){1'b0}}, pullup_control_reg};
        default:           wb_dat_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Pin drive, recomputed every cycle from mode and direction
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      unique case (fn[i])
        PBM_FN_ADDR_OUT: begin
          pin_next[i]    = addr_byte_i[i];
          pin_oe_next[i] = 1'b1;
        end
        PBM_FN_GP_OUT: begin
          pin_next[i]    = output_data_reg[i];
          pin_oe_next[i] = 1'b1;
        end
        default: begin
          pin_next[i]    = 1'b0;
          pin_oe_next[i] = 1'b0;
        end
      endcase
    end
    pullup_next = pull_sel;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_reg  <= PBM_RST_DIRECTION;
      output_data_reg    <= PBM_RST_OUT_DATA;
      pullup_control_reg <= PBM_RST_PULLUP;
      wb_dat_reg         <= 32'h0000_0000;
      wb_ack_reg         <= 1'b0;
      pin_reg            <= '0;
      pin_oe_reg         <= '0;
      pullup_reg         <= '0;
    end else if (ce_i) begin
      pin_direction_reg  <= pin_direction_next;
      output_data_reg    <= output_data_next;
      pullup_control_reg <= pullup_control_next;
      wb_dat_reg         <= wb_dat_next;
      wb_ack_reg         <= wb_ack_next;
      pin_reg            <= pin_next;
      pin_oe_reg         <= pin_oe_next;
      pullup_reg         <= pullup_next;
    end
  end

  always_comb begin
    wb_dat_o = wb_dat_reg;
    wb_ack_o = wb_ack_reg;
    pin_o    = pin_reg;
    pin_oe_o = pin_oe_reg;
    pullup_o = pullup_reg;
  end

  // ==========================================================
  // Checks
  logic mode_12;
  logic mode_47;
  assign mode_12 = (mode_i == PBM_MODE_1) || (mode_i == PBM_MODE_2);
  assign mode_47 = (mode_i == PBM_MODE_4) || (mode_i == PBM_MODE_7);
  logic exp_mode;
  logic mode_other;
  assign exp_mode   = (mode_i == PBM_MODE_4) ||
                      ((mode_i == PBM_MODE_7) && expansion_enable_i);
  assign mode_other = !mode_12 && !mode_47;

  property p_addr_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_12) |=> (pin_oe_o == {PINS{1'b1}}) && (pin_o == $past(addr_byte_i));
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("mode 1/2 pins not address");

  property p_exp_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && (mode_i == PBM_MODE_4 || (mode_i == PBM_MODE_7 && expansion_enable_i)))
      |=> pin_oe_o == $past(pin_direction_reg);
  endproperty
  a_exp_mode: assert property (p_exp_mode) else $error("expanded mode enable wrong");

  property p_io_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_i == PBM_MODE_7 && !expansion_enable_i)
      |=> pin_o == ($past(output_data_reg) & $past(pin_direction_reg));
  endproperty
  a_io_mode: assert property (p_io_mode) else $error("io mode data wrong");

  property p_pull_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && (mode_12 || hw_standby_i)) |=> pullup_o == '0;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up not forced off");

  property p_pull_on;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_47 && !hw_standby_i)
      |=> pullup_o == ($past(pullup_control_reg) & ~$past(pin_direction_reg));
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pull-up state wrong");

  sequence s_read_level;
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == PBM_OFS_PIN_LEVEL;
  endsequence
  property p_level_read;
    @(posedge clk_i) disable iff (rst_i)
      s_read_level |=> wb_ack_o && wb_dat_o[PINS-1:0] ==
        (($past(pin_direction_reg) & $past(output_data_reg)) |
         (~$past(pin_direction_reg) & $past(pin_i)));
  endproperty
  a_level_read: assert property (p_level_read) else $error("pin level read wrong");

  property p_dr_write;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
       wb_adr_i == PBM_OFS_OUT_DATA) |=> output_data_reg == $past(wb_dat_i[PINS-1:0]);
  endproperty
  a_dr_write: assert property (p_dr_write) else $error("data write lost");

  property p_ro_level;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_we_i && wb_adr_i == PBM_OFS_PIN_LEVEL) |=>
        $stable(output_data_reg) && $stable(pin_direction_reg) && $stable(pullup_control_reg);
  endproperty
  a_ro_level: assert property (p_ro_level) else $error("read-only write took effect");

  property p_ack_drop;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_ack_o) |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  property p_exp_data;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && exp_mode) |=> pin_o == ($past(addr_byte_i) & $past(pin_direction_reg));
  endproperty
  a_exp_data: assert property (p_exp_data) else $error("expanded mode address wrong");

  property p_io_oe;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_i == PBM_MODE_7 && !expansion_enable_i)
      |=> pin_oe_o == $past(pin_direction_reg);
  endproperty
  a_io_oe: assert property (p_io_oe) else $error("io mode enable wrong");

  property p_other_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_other) |=> (pin_oe_o == '0) && (pullup_o == '0);
  endproperty
  a_other_mode: assert property (p_other_mode) else $error("unsupported mode not all input");

  sequence s_dir_write;
    ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
    wb_adr_i == PBM_OFS_DIRECTION;
  endsequence
  property p_dir_write;
    @(posedge clk_i) disable iff (rst_i)
      s_dir_write |=> pin_direction_reg == $past(wb_dat_i[PINS-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  sequence s_pull_write;
    ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
    wb_adr_i == PBM_OFS_PULLUP;
  endsequence
  property p_pull_write;
    @(posedge clk_i) disable iff (rst_i)
      s_pull_write |=> pullup_control_reg == $past(wb_dat_i[PINS-1:0]);
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");

  sequence s_dir_read;
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == PBM_OFS_DIRECTION;
  endsequence
  property p_dir_read;
    @(posedge clk_i) disable iff (rst_i)
      s_dir_read |=> wb_ack_o && (wb_dat_o == PBM_UNDEF_READ);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not junk");

  property p_dr_read;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == PBM_OFS_OUT_DATA)
      |=> wb_dat_o[PINS-1:0] == $past(output_data_reg);
  endproperty
  a_dr_read: assert property (p_dr_read) else $error("data read wrong");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(pin_o) && $stable(pin_oe_o) && $stable(pullup_o) && $stable(wb_ack_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
endmodule
